// ---- src/acg_pkg.sv ----
package acg_pkg;
	localparam int          ACG_ADDR_W          = 8;
	localparam logic [7:0]  ACG_GATES_OFFSET    = 8'h1C;
	localparam logic [7:0]  ACG_BACKUP_OFFSET   = 8'h20;
	localparam logic [31:0] ACG_GATES_RESET     = 32'h0000_0000;
	localparam logic [31:0] ACG_BACKUP_RESET    = 32'h0000_0018;
	// Writable bits of the gating register
	localparam logic [31:0] ACG_GATES_MASK      = 32'h7A7E_4933;
	localparam int          ACG_OSC_ON_BIT      = 0;
	localparam int          ACG_OSC_STABLE_BIT  = 1;
	localparam int          ACG_BYPASS_BIT      = 2;
	localparam int          ACG_DRIVE_LSB       = 3;
	localparam int          ACG_SRC_LSB         = 8;
	localparam int          ACG_CAL_GATE_BIT    = 15;
	localparam int          ACG_SOFT_RST_BIT    = 16;
	localparam logic [1:0]  ACG_DRIVE_RESET     = 2'h3;
	localparam logic [1:0]  ACG_SRC_NONE        = 2'h0;
	// Wait cycles for a back-to-back backup access
	localparam logic [1:0]  ACG_BACKUP_WAITS    = 2'h3;
endpackage : acg_pkg

// ---- src/acg_clock_gate_ctrl.sv ----
`timescale 1ns/1ps
module acg_clock_gate_ctrl
	import acg_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  calendar_domain_reset,
	input  wire logic [ACG_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	output logic      [1:0]            avs_response,
	input  wire logic                  periph_busy,
	input  wire logic                  periph_sel_valid,
	input  wire logic [4:0]            periph_sel_bit,
	input  wire logic [31:0]           periph_rdata,
	output logic      [31:0]           periph_rdata_gated,
	input  wire logic                  backup_write_unlock,
	input  wire logic                  slow_ext_osc_ready_pin,
	output logic      [31:0]           periph_clk_en,
	output logic                       slow_ext_osc_on,
	output logic                       slow_ext_bypass,
	output logic      [1:0]            slow_ext_drive_strength,
	output logic      [1:0]            calendar_clock_source,
	output logic                       calendar_clock_gate,
	output logic                       backup_domain_in_reset
);

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	logic [31:0] gates_q;
	logic        osc_on_q;
	logic        bypass_q;
	logic [1:0]  drive_q;
	logic [1:0]  src_q;
	logic        cal_gate_q;
	logic        soft_rst_q;
	logic [2:0]  rdy_sync_q;
	logic        stable_q;
	logic [1:0]  wait_cnt_q;
	logic        backup_prev_q;
	logic        done_q;

	wire logic        req       = avs_read | avs_write;
	wire logic        hit_gates = avs_address == ACG_GATES_OFFSET;
	wire logic        hit_back  = avs_address == ACG_BACKUP_OFFSET;
	wire logic [31:0] bm        = be_mask(avs_byteenable);
	wire logic        bkp_rst   = calendar_domain_reset | soft_rst_q;
	logic             accept;

	always_comb begin
		accept = 1'b0;
		if (req && !done_q) begin
			if (hit_gates)
				accept = !periph_busy;
			else if (hit_back)
				accept = !backup_prev_q || (wait_cnt_q == ACG_BACKUP_WAITS);
			else
				accept = 1'b1;
		end
	end

	// Wait counter for back-to-back backup accesses
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			wait_cnt_q <= 2'h0;
		else if (req && hit_back && backup_prev_q && !accept && !done_q)
			wait_cnt_q <= wait_cnt_q + 2'h1;
		else
			wait_cnt_q <= 2'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			backup_prev_q <= 1'b0;
		else if (accept)
			backup_prev_q <= hit_back;
		else if (!req)
			backup_prev_q <= 1'b0;
	end

	// Registered answer; done pulse blocks a second accept so waitrequest drops for one edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			done_q <= 1'b0;
		else
			done_q <= accept;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !accept;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end else if (accept) begin
			avs_response <= (hit_gates || hit_back) ? 2'h0 : 2'h2;
			if (!avs_read)
				avs_readdata <= 32'h0000_0000;
			else if (hit_gates)
				avs_readdata <= gates_q;
			else if (hit_back)
				avs_readdata <= {15'h0, soft_rst_q, cal_gate_q, 5'h0, src_q, 3'h0,
					drive_q, bypass_q, stable_q, osc_on_q};
			else
				avs_readdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			gates_q <= ACG_GATES_RESET;
		else if (accept && avs_write && hit_gates)
			gates_q <= ((gates_q & ~bm) | (avs_writedata & bm)) & ACG_GATES_MASK;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			periph_clk_en <= ACG_GATES_RESET;
		else
			periph_clk_en <= gates_q;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			periph_rdata_gated <= 32'h0000_0000;
		else if (periph_sel_valid && gates_q[periph_sel_bit])
			periph_rdata_gated <= periph_rdata;
		else
			periph_rdata_gated <= 32'h0000_0000;
	end

	// Soft reset bit, cleared by domain reset or a write of zero, not by sys_rst
	always_ff @(posedge ref_clk) begin
		if (calendar_domain_reset)
			soft_rst_q <= 1'b0;
		else if (accept && avs_write && hit_back && avs_byteenable[2])
			soft_rst_q <= avs_writedata[ACG_SOFT_RST_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (bkp_rst)
			drive_q <= ACG_DRIVE_RESET;
		else if (accept && avs_write && hit_back && avs_byteenable[0])
			drive_q <= avs_writedata[ACG_DRIVE_LSB +: 2];
	end

	always_ff @(posedge ref_clk) begin
		if (bkp_rst) begin
			osc_on_q <= ACG_BACKUP_RESET[ACG_OSC_ON_BIT];
			bypass_q <= ACG_BACKUP_RESET[ACG_BYPASS_BIT];
		end else if (accept && avs_write && hit_back && avs_byteenable[0]
				&& backup_write_unlock) begin
			osc_on_q <= avs_writedata[ACG_OSC_ON_BIT];
			bypass_q <= avs_writedata[ACG_BYPASS_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (bkp_rst)
			src_q <= ACG_SRC_NONE;
		else if (accept && avs_write && hit_back && avs_byteenable[1]
				&& backup_write_unlock && src_q == ACG_SRC_NONE)
			src_q <= avs_writedata[ACG_SRC_LSB +: 2];
	end

	always_ff @(posedge ref_clk) begin
		if (bkp_rst)
			cal_gate_q <= 1'b0;
		else if (accept && avs_write && hit_back && avs_byteenable[1]
				&& backup_write_unlock)
			cal_gate_q <= avs_writedata[ACG_CAL_GATE_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			rdy_sync_q <= 3'h0;
		else
			rdy_sync_q <= {rdy_sync_q[1:0], slow_ext_osc_ready_pin};
	end

	always_ff @(posedge ref_clk) begin
		if (bkp_rst || !osc_on_q)
			stable_q <= 1'b0;
		else if (rdy_sync_q[2] == rdy_sync_q[1])
			stable_q <= rdy_sync_q[2];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			slow_ext_osc_on         <= 1'b0;
			slow_ext_bypass         <= 1'b0;
			slow_ext_drive_strength <= ACG_DRIVE_RESET;
			calendar_clock_source   <= ACG_SRC_NONE;
			calendar_clock_gate     <= 1'b0;
			backup_domain_in_reset  <= 1'b0;
		end else begin
			slow_ext_osc_on         <= osc_on_q;
			slow_ext_bypass         <= bypass_q;
			slow_ext_drive_strength <= drive_q;
			calendar_clock_source   <= src_q;
			calendar_clock_gate     <= cal_gate_q;
			backup_domain_in_reset  <= bkp_rst;
		end
	end

endmodule : acg_clock_gate_ctrl

// ---- sim/acg_asserts.sv ----
`timescale 1ns/1ps
module acg_asserts
	import acg_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	input wire logic                  calendar_domain_reset,
	input wire logic [ACG_ADDR_W-1:0] avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	input wire logic                  periph_busy,
	input wire logic                  periph_sel_valid,
	input wire logic [4:0]            periph_sel_bit,
	input wire logic [31:0]           periph_rdata_gated,
	input wire logic [31:0]           periph_clk_en,
	input wire logic                  backup_write_unlock,
	input wire logic                  slow_ext_osc_on,
	input wire logic [1:0]            slow_ext_drive_strength,
	input wire logic [1:0]            calendar_clock_source,
	input wire logic                  calendar_clock_gate,
	input wire logic                  backup_domain_in_reset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire bkp_req = (avs_read || avs_write) && avs_address == ACG_BACKUP_OFFSET;
	wire gate_req = (avs_read || avs_write) && avs_address == ACG_GATES_OFFSET;
	sequence s_b2b; !avs_waitrequest && bkp_req ##1 bkp_req; endsequence
	sequence s_slow_answer; avs_waitrequest [*3] ##1 !avs_waitrequest; endsequence
	property p_b2b; s_b2b |=> s_slow_answer; endproperty
	a_b2b: assert property (p_b2b) else $error("backup wait count");
	property p_fast; $rose(avs_read) && gate_req && !periph_busy |=> !avs_waitrequest; endproperty
	a_fast: assert property (p_fast) else $error("gating answer late");
	property p_busy; gate_req && periph_busy |=> avs_waitrequest; endproperty
	a_busy: assert property (p_busy) else $error("no stall on busy");
	property p_mask; (periph_clk_en & ~ACG_GATES_MASK) == 32'h0; endproperty
	a_mask: assert property (p_mask) else $error("reserved enable set");
	property p_gated; periph_sel_valid && !periph_clk_en[periph_sel_bit] |=> periph_rdata_gated == 32'h0; endproperty
	a_gated: assert property (p_gated) else $error("disabled read not zero");
	property p_cal; calendar_domain_reset [*2] |=> slow_ext_drive_strength == 2'h3 && calendar_clock_source == 2'h0 && !slow_ext_osc_on; endproperty
	a_cal: assert property (p_cal) else $error("backup reset value");
	property p_soft; backup_domain_in_reset |=> calendar_clock_source == 2'h0 && !calendar_clock_gate && !slow_ext_osc_on; endproperty
	a_soft: assert property (p_soft) else $error("soft reset not held");
	property p_lock; $rose(calendar_clock_gate) |-> $past(backup_write_unlock, 2); endproperty
	a_lock: assert property (p_lock) else $error("gate set while locked");
endmodule : acg_asserts
bind acg_clock_gate_ctrl acg_asserts i_acg_asserts (.*);

// ---- sim/test_acg_clock_gate_ctrl.sv ----
`timescale 1ns/1ps
module test_acg_clock_gate_ctrl
	import acg_pkg::*;
;
	logic ref_clk = 1'h0, sys_rst = 1'h1, calendar_domain_reset = 1'h1, avs_read = 1'h0;
	logic avs_write = 1'h0, periph_busy = 1'h0, periph_sel_valid = 1'h0;
	logic backup_write_unlock = 1'h0, slow_ext_osc_ready_pin = 1'h0;
	logic [ACG_ADDR_W-1:0] avs_address = 8'h0;
	logic [31:0] avs_writedata = 32'h0, periph_rdata = 32'hA5A5_A5A5;
	logic [31:0] avs_readdata, periph_rdata_gated, periph_clk_en;
	logic [3:0] avs_byteenable = 4'hF;
	logic [4:0] periph_sel_bit = 5'h0;
	logic [1:0] avs_response, slow_ext_drive_strength, calendar_clock_source;
	logic avs_waitrequest, slow_ext_osc_on, slow_ext_bypass, calendar_clock_gate;
	logic backup_domain_in_reset;
	int errors = 0, check_count = 0;
	acg_clock_gate_ctrl i_acg_clock_gate_ctrl (.*);
	always #2 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 40);
		if (n >= 40) errors++;
	endtask : acc
	task automatic idle();
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge ref_clk);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		acc(1'h1, a, d, be);
		idle();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'h0, a, 32'h0, 4'hF);
		chk(avs_readdata, exp);
		idle();
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		#40000;
		errors++;
		complete_run();
	end
	initial begin
		tick(3);
		sys_rst <= 1'h0;
		calendar_domain_reset <= 1'h0;
		tick(1);
		rd(8'h1C, 32'h0);
		rd(8'h20, 32'h18);
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h7A7E_4933);
		wr(8'h1C, 32'h0, 4'h1);
		rd(8'h1C, 32'h7A7E_4900);
		tick(2);
		chk(periph_clk_en, 32'h7A7E_4900);
		periph_sel_valid <= 1'h1;
		tick(2);
		chk(periph_rdata_gated, 32'h0);
		periph_sel_bit <= 5'h8;
		tick(2);
		chk(periph_rdata_gated, 32'hA5A5_A5A5);
		periph_sel_valid <= 1'h0;
		periph_busy <= 1'h1;
		fork
			rd(8'h1C, 32'h7A7E_4900);
			begin tick(5); periph_busy <= 1'h0; end
		join
		$display("gating test done");
		wr(8'h20, 32'h0000_8301);
		rd(8'h20, 32'h0);
		backup_write_unlock <= 1'h1;
		tick(1);
		acc(1'h1, 8'h20, 32'h0000_8105, 4'hF);
		acc(1'h1, 8'h20, 32'h0000_8205, 4'hF);
		rd(8'h20, 32'h0000_8105);
		slow_ext_osc_ready_pin <= 1'h1;
		tick(6);
		rd(8'h20, 32'h0000_8107);
		chk({29'h0, slow_ext_osc_on, slow_ext_bypass, calendar_clock_gate}, 32'h7);
		slow_ext_osc_ready_pin <= 1'h0;
		tick(6);
		wr(8'h20, 32'h0001_8105);
		rd(8'h20, 32'h0001_0018);
		chk({31'h0, backup_domain_in_reset}, 32'h1);
		wr(8'h20, 32'h0);
		wr(8'h20, 32'h0000_0218);
		rd(8'h20, 32'h0000_0218);
		chk({28'h0, slow_ext_drive_strength, calendar_clock_source}, 32'hE);
		chk({31'h0, backup_domain_in_reset}, 32'h0);
		$display("backup test done");
		sys_rst <= 1'h1;
		tick(3);
		sys_rst <= 1'h0;
		tick(1);
		rd(8'h20, 32'h0000_0218);
		rd(8'h1C, 32'h0);
		calendar_domain_reset <= 1'h1;
		tick(2);
		calendar_domain_reset <= 1'h0;
		tick(1);
		rd(8'h20, 32'h18);
		acc(1'h0, 8'h24, 32'h0, 4'hF);
		chk({30'h0, avs_response}, 32'h2);
		idle();
		$display("reset domain test done");
		complete_run();
	end
endmodule : test_acg_clock_gate_ctrl
